// >>> dumpc_top.sv
/*
  Dual serial channel modem handshake and pin controller. Each channel has
  modem control, interrupt enable, divisor, line status and modem status
  registers, a transmit serialiser and the modem pins.
  Assumes one core clock, synchronous active-low reset, a one-cycle read
  and write strobe register port, and modem pins asynchronous to the clock.
*/
`timescale 1ns/10ps
module dumpc_top
  import dumpc_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [DUMPC_ADDR_W-1:0] i_addr,
  input wire logic [DUMPC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DUMPC_DATA_W-1:0] o_rdata,
  input wire logic [CHANNELS-1:0] i_carrier_detect_n,
  input wire logic [CHANNELS-1:0] i_clear_to_send_n,
  input wire logic [CHANNELS-1:0] i_data_set_ready_n,
  input wire logic [CHANNELS-1:0] i_ring_indicator_n,
  input wire logic [CHANNELS-1:0] i_rxd,
  output logic [CHANNELS-1:0] o_terminal_ready_n,
  output logic [CHANNELS-1:0] o_request_to_send_n,
  output logic [CHANNELS-1:0] o_txd,
  output logic [CHANNELS-1:0] o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // shared decode

  logic [2:0] offset;
  logic [CHANNELS-1:0][DUMPC_DATA_W-1:0] chan_rdata;
  logic [DUMPC_DATA_W-1:0] rdata_next;

  // low bits pick the register, the channel bit picks the channel
  assign offset = i_addr[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // per-channel logic

  for (genvar g = 0; g < CHANNELS; g++) begin : ch_gen

    logic sel;
    logic wr_hit;
    logic [4:0] modem_control_reg;
    logic [3:0] irq_enable_reg;
    logic [15:0] divisor_reg;
    logic [15:0] baud_cnt_reg;
    logic tick_reg;
    logic [3:0] delta_reg;
    logic [3:0] delta_next;
    logic [3:0] events;
    logic [3:0] clear_mask;
    logic [3:0] pins_s;
    logic [3:0] pins_prev_reg;
    logic rx_line;
    logic rx_level_reg;
    logic [DUMPC_DATA_W-1:0] modem_status_reg;
    logic [DUMPC_DATA_W-1:0] line_status;

    dumpc_tx_if txc ();

    // address match keeps each channel to its own registers
    assign sel = (i_addr[DUMPC_CHAN_BIT] == 1'(g));
    assign wr_hit = i_wr & sel;

    //////////////////////////////////////////////////////////////////////////
    // modem inputs, order carrier, ring, dsr, cts (msb to lsb)

    // every modem level is resynchronised before use
    dumpc_sync #(
      .W(4),
      .RST_VAL(DUMPC_PIN_IDLE)
    ) u_modem_sync (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_async({i_carrier_detect_n[g], i_ring_indicator_n[g],
                i_data_set_ready_n[g], i_clear_to_send_n[g]}),
      .o_sync(pins_s)
    );

    // previous synchronised level for change detection
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        pins_prev_reg <= {4{DUMPC_PIN_IDLE}};
      end else begin
        pins_prev_reg <= pins_s;
      end
    end

    // change on cts, dsr, carrier; ring only when the input returns high
    assign events[DUMPC_MSTAT_D_CTS] = pins_s[0] ^ pins_prev_reg[0];
    assign events[DUMPC_MSTAT_D_DSR] = pins_s[1] ^ pins_prev_reg[1];
    assign events[DUMPC_MSTAT_RING_END] =
      pins_s[2] & ~pins_prev_reg[2];
    assign events[DUMPC_MSTAT_D_CAR] = pins_s[3] ^ pins_prev_reg[3];

    //////////////////////////////////////////////////////////////////////////
    // sticky event bits: write one clears, a new event wins

    always_comb begin
      clear_mask = 4'h0;
      if (wr_hit && offset == DUMPC_OFF_MSTAT) begin
        clear_mask = i_wdata[3:0];
      end
      delta_next = (delta_reg & ~clear_mask) | events;
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        delta_reg <= DUMPC_MSTAT_D_RST;
      end else begin
        delta_reg <= delta_next;
      end
    end

    // live levels reported active high in the upper nibble
    always_comb begin
      modem_status_reg = {DUMPC_DATA_W{1'b0}};
      modem_status_reg[3:0] = delta_reg;
      modem_status_reg[DUMPC_MSTAT_CTS] = ~pins_s[0];
      modem_status_reg[DUMPC_MSTAT_DSR] = ~pins_s[1];
      modem_status_reg[DUMPC_MSTAT_RING] = ~pins_s[2];
      modem_status_reg[DUMPC_MSTAT_CAR] = ~pins_s[3];
    end

    //////////////////////////////////////////////////////////////////////////
    // control registers

    // modem control: terminal ready, request to send, gate, loopback
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        modem_control_reg <= DUMPC_MCTL_RST;
      end else if (wr_hit && offset == DUMPC_OFF_MCTL) begin
        modem_control_reg <= i_wdata[4:0] & DUMPC_MCTL_MASK;
      end
    end

    // per-event interrupt enables, same layout as the event bits
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        irq_enable_reg <= DUMPC_IEN_RST;
      end else if (wr_hit && offset == DUMPC_OFF_IEN) begin
        irq_enable_reg <= i_wdata[3:0];
      end
    end

    // bit time divisor, low and high byte
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        divisor_reg <= DUMPC_DIV_RST;
      end else if (wr_hit && offset == DUMPC_OFF_DLL) begin
        divisor_reg[7:0] <= i_wdata;
      end else if (wr_hit && offset == DUMPC_OFF_DLM) begin
        divisor_reg[15:8] <= i_wdata;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // bit rate divider: one tick every divisor+1 cycles

    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        baud_cnt_reg <= 16'h0000;
        tick_reg <= 1'b0;
      end else if (baud_cnt_reg >= divisor_reg) begin
        baud_cnt_reg <= 16'h0000;
        tick_reg <= 1'b1;
      end else begin
        baud_cnt_reg <= baud_cnt_reg + 16'h0001;
        tick_reg <= 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // transmitter; a write while busy is dropped

    assign txc.load = wr_hit & (offset == DUMPC_OFF_THR) & ~txc.busy;
    assign txc.data = i_wdata;
    assign txc.tick = tick_reg;

    dumpc_tx u_tx (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .port(txc)
    );

    //////////////////////////////////////////////////////////////////////////
    // receive line: looped transmit data or the external pin

    // loopback ignores the external pin entirely
    assign rx_line = modem_control_reg[DUMPC_MCTL_LOOP] ?
                     txc.serial : i_rxd[g];

    // sampled line, held idle high through reset
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        rx_level_reg <= DUMPC_PIN_IDLE;
      end else begin
        rx_level_reg <= rx_line;
      end
    end

    // line status: transmitter busy and receive level
    always_comb begin
      line_status = {DUMPC_DATA_W{1'b0}};
      line_status[DUMPC_LSR_TX_BUSY] = txc.busy;
      line_status[DUMPC_LSR_RX_LEVEL] = rx_level_reg;
    end

    //////////////////////////////////////////////////////////////////////////
    // pin outputs, all registered

    // modem outputs follow their control bits only
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        o_terminal_ready_n[g] <= DUMPC_PIN_IDLE;
        o_request_to_send_n[g] <= DUMPC_PIN_IDLE;
      end else begin
        o_terminal_ready_n[g] <=
          ~modem_control_reg[DUMPC_MCTL_DTR];
        o_request_to_send_n[g] <=
          ~modem_control_reg[DUMPC_MCTL_RTS];
      end
    end

    // external transmit held idle high in reset and in loopback
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        o_txd[g] <= DUMPC_PIN_IDLE;
      end else if (modem_control_reg[DUMPC_MCTL_LOOP]) begin
        o_txd[g] <= DUMPC_PIN_IDLE;
      end else begin
        o_txd[g] <= txc.serial;
      end
    end

    // interrupt needs the gate bit and an enabled pending event
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        o_irq[g] <= 1'b0;
      end else begin
        o_irq[g] <= modem_control_reg[DUMPC_MCTL_IRQ_GATE] &
                    (|(delta_reg & irq_enable_reg));
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // read mux for this channel; unmapped offsets read zero

    always_comb begin
      chan_rdata[g] = {DUMPC_DATA_W{1'b0}};
      unique case (offset)
        DUMPC_OFF_IEN: chan_rdata[g] = {4'h0, irq_enable_reg};
        DUMPC_OFF_DLL: chan_rdata[g] = divisor_reg[7:0];
        DUMPC_OFF_DLM: chan_rdata[g] = divisor_reg[15:8];
        DUMPC_OFF_MCTL: chan_rdata[g] = {3'h0, modem_control_reg};
        DUMPC_OFF_LSR: chan_rdata[g] = line_status;
        DUMPC_OFF_MSTAT: chan_rdata[g] = modem_status_reg;
        default: chan_rdata[g] = {DUMPC_DATA_W{1'b0}};
      endcase
    end

  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the read strobe

  always_comb begin
    rdata_next = {DUMPC_DATA_W{1'b0}};
    if (i_rd) begin
      rdata_next = chan_rdata[i_addr[DUMPC_CHAN_BIT]];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_rdata <= {DUMPC_DATA_W{1'b0}};
    end else begin
      o_rdata <= rdata_next;
    end
  end

endmodule

// >>> dumpc_pkg.sv
/*
  Constants of the dual serial channel modem and pin controller: register
  offsets, field positions, reset values and frame sizes.
  Assumes the top and its leaves import it whole; no clock or reset here.
*/
// Function
// - each channel accepts an active-low carrier detect input, low means carrier present.
// - clear to send level reported at status bit 4, never gates transfers.
// - active-low data set ready is reported only, never affects transfers.
// - control bit 0 set drives terminal ready low; clear or reset drives high.
// - terminal ready output is status only, no effect on transfers.
// - ring input rising to high raises a modem status event for its channel.
// - control bit 1 set drives request to send low; clear drives high.
// - after reset request to send stays high until software sets it.
// - transmit output sits high in reset, when idle and when disabled.
// - loopback disables external transmit and feeds transmit data to own receiver.
// - loopback ignores the external receive input, sampling only looped data.
// - interrupt needs control bit 3, an enabled source and a pending event.
// - active-low master reset returns all registers and outputs to reset state.
package dumpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int DUMPC_DATA_W = 8;
  localparam int DUMPC_ADDR_W = 4;
  localparam int DUMPC_CHAN_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel register offsets (low three address bits)
  localparam logic [2:0] DUMPC_OFF_THR = 3'h0;
  localparam logic [2:0] DUMPC_OFF_IEN = 3'h1;
  localparam logic [2:0] DUMPC_OFF_DLL = 3'h2;
  localparam logic [2:0] DUMPC_OFF_DLM = 3'h3;
  localparam logic [2:0] DUMPC_OFF_MCTL = 3'h4;
  localparam logic [2:0] DUMPC_OFF_LSR = 3'h5;
  localparam logic [2:0] DUMPC_OFF_MSTAT = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // modem control fields
  localparam int DUMPC_MCTL_DTR = 0;
  localparam int DUMPC_MCTL_RTS = 1;
  localparam int DUMPC_MCTL_IRQ_GATE = 3;
  localparam int DUMPC_MCTL_LOOP = 4;
  localparam logic [4:0] DUMPC_MCTL_MASK = 5'h1B;

  // modem status fields: sticky events low, live levels high
  localparam int DUMPC_MSTAT_D_CTS = 0;
  localparam int DUMPC_MSTAT_D_DSR = 1;
  localparam int DUMPC_MSTAT_RING_END = 2;
  localparam int DUMPC_MSTAT_D_CAR = 3;
  localparam int DUMPC_MSTAT_CTS = 4;
  localparam int DUMPC_MSTAT_DSR = 5;
  localparam int DUMPC_MSTAT_RING = 6;
  localparam int DUMPC_MSTAT_CAR = 7;
  localparam int DUMPC_EVENTS = 4;

  // line status fields
  localparam int DUMPC_LSR_TX_BUSY = 0;
  localparam int DUMPC_LSR_RX_LEVEL = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [4:0] DUMPC_MCTL_RST = 5'h00;
  localparam logic [3:0] DUMPC_IEN_RST = 4'h0;
  localparam logic [15:0] DUMPC_DIV_RST = 16'h0001;
  localparam logic [3:0] DUMPC_MSTAT_D_RST = 4'h0;
  localparam logic DUMPC_PIN_IDLE = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // frame: start, data bits, one stop
  localparam int DUMPC_FRAME_BITS = DUMPC_DATA_W + 2;
  localparam int DUMPC_SYNC_STAGES = 2;

endpackage

// >>> dumpc_tx_if.sv
/*
  Carrier between the channel controller and its transmit serialiser.
  Assumes both ends run on the same core clock; no clocking here.
*/
`timescale 1ns/10ps
interface dumpc_tx_if;
  logic load;
  logic [7:0] data;
  logic tick;
  logic busy;
  logic serial;

  modport ctrl (output load, output data, output tick,
                input busy, input serial);
  modport tx (input load, input data, input tick,
              output busy, output serial);
endinterface

// >>> dumpc_sync.sv
/*
  Two-flop level synchroniser, one bit per lane.
  Assumes synchronous active-low reset; reset value is a constant parameter.
*/
`timescale 1ns/10ps
module dumpc_sync #(
  parameter int W = 4,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  //////////////////////////////////////////////////////////////////////////
  // first stage feeds the second stage only
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      meta_reg <= {W{RST_VAL}};
      o_sync <= {W{RST_VAL}};
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// >>> dumpc_tx.sv
/*
  Transmit serialiser: start bit, data bits lsb first, one stop bit.
  Assumes one tick pulse per bit time from the controller and that load
  arrives only while busy is low.
*/
`timescale 1ns/10ps
module dumpc_tx
  import dumpc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  dumpc_tx_if.tx port
);
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } dumpc_tx_state_type;

  dumpc_tx_state_type state_reg;
  logic [DUMPC_FRAME_BITS-1:0] shift_reg;
  logic [3:0] count_reg;

  assign port.busy = (state_reg == TX_SEND);

  //////////////////////////////////////////////////////////////////////////
  // frame sequencer; line rests high outside a frame
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state_reg <= TX_IDLE;
      shift_reg <= '1;
      count_reg <= 4'h0;
      port.serial <= DUMPC_PIN_IDLE;
    end else begin
      unique case (state_reg)
        TX_IDLE: begin
          port.serial <= DUMPC_PIN_IDLE;
          count_reg <= 4'h0;
          if (port.load) begin
            shift_reg <= {1'b1, port.data, 1'b0};
            state_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (port.tick) begin
            if (count_reg == 4'(DUMPC_FRAME_BITS)) begin
              state_reg <= TX_IDLE;
              port.serial <= DUMPC_PIN_IDLE;
            end else begin
              port.serial <= shift_reg[0];
              shift_reg <= {1'b1, shift_reg[DUMPC_FRAME_BITS-1:1]};
              count_reg <= count_reg + 4'h1;
            end
          end
        end
      endcase
    end
  end
endmodule

// >>> dumpc_modem_model.sv
/*
  Far side of one serial port pair: modem levels and the receive line.
  Assumes the bench sets the levels; receive idles high unless driven.
*/
`timescale 1ns/10ps
module dumpc_modem_model (
  input wire logic [7:0] i_levels_n,
  input wire logic [1:0] i_rx_drive,
  input wire logic [1:0] i_rx_val,
  output logic [1:0] o_carrier_detect_n,
  output logic [1:0] o_clear_to_send_n,
  output logic [1:0] o_data_set_ready_n,
  output logic [1:0] o_ring_indicator_n,
  output logic [1:0] o_rxd
);
  // modem levels packed carrier, clear, ready, ring
  assign {o_carrier_detect_n, o_clear_to_send_n} = i_levels_n[7:4];
  assign {o_data_set_ready_n, o_ring_indicator_n} = i_levels_n[3:0];
  // line stays high while the far transmitter is idle
  assign o_rxd = (i_rx_val & i_rx_drive) | ~i_rx_drive;
endmodule

// >>> dumpc_asserts.sv
/*
  Port checker for the dual channel modem pin controller.
  Assumes one core clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
module dumpc_asserts
  import dumpc_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [DUMPC_ADDR_W-1:0] i_addr,
  input wire logic [DUMPC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DUMPC_DATA_W-1:0] o_rdata,
  input wire logic [CHANNELS-1:0] i_carrier_detect_n,
  input wire logic [CHANNELS-1:0] i_clear_to_send_n,
  input wire logic [CHANNELS-1:0] i_data_set_ready_n,
  input wire logic [CHANNELS-1:0] i_ring_indicator_n,
  input wire logic [CHANNELS-1:0] i_rxd,
  input wire logic [CHANNELS-1:0] o_terminal_ready_n,
  input wire logic [CHANNELS-1:0] o_request_to_send_n,
  input wire logic [CHANNELS-1:0] o_txd,
  input wire logic [CHANNELS-1:0] o_irq
);
  logic [2:0] age_reg;
  logic [1:0] gate_reg;
  logic [1:0] loop_reg;
  logic [1:0][3:0] ien_reg;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // cycles since reset, saturating
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  // shadow of gate, loopback and enables
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      gate_reg <= 2'h0;
      loop_reg <= 2'h0;
      ien_reg <= '0;
    end else if (i_wr && i_addr[2:0] == DUMPC_OFF_MCTL) begin
      gate_reg[i_addr[3]] <= i_wdata[DUMPC_MCTL_IRQ_GATE];
      loop_reg[i_addr[3]] <= i_wdata[DUMPC_MCTL_LOOP];
    end else if (i_wr && i_addr[2:0] == DUMPC_OFF_IEN) begin
      ien_reg[i_addr[3]] <= i_wdata[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_dtr_follow;
    i_wr && i_addr == 4'h4 |->
      ##2 o_terminal_ready_n[0] == ~$past(i_wdata[0], 2);
  endproperty
  a_dtr_follow: assert property (p_dtr_follow)
    else $error("dtr mismatch");
  property p_rts_follow;
    i_wr && i_addr == 4'hC |->
      ##2 o_request_to_send_n[1] == ~$past(i_wdata[1], 2);
  endproperty
  a_rts_follow: assert property (p_rts_follow)
    else $error("rts mismatch");
  property p_reset_outs;
    disable iff (1'b0) !i_rstn |=> o_terminal_ready_n == 2'h3 &&
      o_request_to_send_n == 2'h3 && o_txd == 2'h3 && o_irq == 2'h0 &&
      o_rdata == 8'h00;
  endproperty
  a_reset_outs: assert property (p_reset_outs)
    else $error("reset out");
  property p_irq_gate;
    o_irq[0] |-> $past(gate_reg[0]) && $past(ien_reg[0]) != 4'h0;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq ungated");
  property p_ring_irq;
    $rose(i_ring_indicator_n[0]) && age_reg == 3'h7 && gate_reg[0] &&
      ien_reg[0][DUMPC_MSTAT_RING_END] |-> ##4 o_irq[0];
  endproperty
  a_ring_irq: assert property (p_ring_irq)
    else $error("ring no irq");
  property p_loop_txd;
    loop_reg[0] && $past(loop_reg[0]) |-> o_txd[0];
  endproperty
  a_loop_txd: assert property (p_loop_txd)
    else $error("loop txd low");
  property p_cts_level;
    $stable(i_clear_to_send_n[0])[*3] ##0
      (i_rd && i_addr == 4'h6 && age_reg == 3'h7)
      |=> o_rdata[DUMPC_MSTAT_CTS] == ~$past(i_clear_to_send_n[0]);
  endproperty
  a_cts_level: assert property (p_cts_level)
    else $error("cts level");
  property p_car_level;
    $stable(i_carrier_detect_n[1])[*3] ##0
      (i_rd && i_addr == 4'hE && age_reg == 3'h7)
      |=> o_rdata[DUMPC_MSTAT_CAR] == ~$past(i_carrier_detect_n[1]);
  endproperty
  a_car_level: assert property (p_car_level)
    else $error("carrier level");
  property p_chan_split;
    i_wr && !i_addr[3] |-> ##2 $stable(o_terminal_ready_n[1]) &&
      $stable(o_request_to_send_n[1]);
  endproperty
  a_chan_split: assert property (p_chan_split)
    else $error("cross chan");
endmodule
bind dumpc_top dumpc_asserts #(.CHANNELS(CHANNELS)) u_dumpc_asserts (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd),
  .i_carrier_detect_n(i_carrier_detect_n), .i_clear_to_send_n(i_clear_to_send_n),
  .i_data_set_ready_n(i_data_set_ready_n), .o_irq(o_irq),
  .i_ring_indicator_n(i_ring_indicator_n), .o_terminal_ready_n(o_terminal_ready_n),
  .o_request_to_send_n(o_request_to_send_n));

// >>> testbench.sv
/*
  Self-checking bench for the dual channel modem pin controller.
  Assumes the modem model on the far side and a 4 ns core clock.
*/
`timescale 1ns/10ps
module testbench;
  import dumpc_pkg::*;
  logic i_core_clk, i_rstn, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, lv, rd;
  logic [1:0] car_n, cts_n, dsr_n, ring_n, rxd, dtr_n, rts_n, txd, irq;
  logic [1:0] rx_drive, rx_val;
  int num_errors, num_checks;
  dumpc_top #(.CHANNELS(2)) u_dumpc_top (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_carrier_detect_n(car_n), .i_clear_to_send_n(cts_n),
    .i_data_set_ready_n(dsr_n), .i_ring_indicator_n(ring_n), .i_rxd(rxd),
    .o_terminal_ready_n(dtr_n),
    .o_request_to_send_n(rts_n), .o_txd(txd), .o_irq(irq));
  dumpc_modem_model u_dumpc_modem_model (.i_levels_n(lv), .i_rx_drive(rx_drive),
    .i_rx_val(rx_val), .o_carrier_detect_n(car_n), .o_clear_to_send_n(cts_n),
    .o_data_set_ready_n(dsr_n), .o_ring_indicator_n(ring_n), .o_rxd(rxd));
  // core clock
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    num_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("reg %h want %h", got, exp));
  endtask
  task automatic check_pin(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("pins %b want %b", got, exp));
  endtask
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1 check_pin(dtr_n, 2'h3);
    check_pin(rts_n, 2'h3);
    check_pin(txd, 2'h3);
    rdr(4'h4, rd);
    check_reg(rd, 8'h00);
    rdr(4'h9, rd);
    check_reg(rd, 8'h00);
    rdr(4'h7, rd);
    check_reg(rd, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_ctrl;
    logic [1:0] ed, er;
    ed = 2'h3;
    er = 2'h3;
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr({c[0], DUMPC_OFF_MCTL}, m[7:0]);
        ed[c] = ~m[0];
        er[c] = ~m[1];
        @(posedge i_core_clk);
        #1 check_pin(dtr_n, ed);
        check_pin(rts_n, er);
        check_pin(txd, 2'h3);
        rdr({c[0], DUMPC_OFF_MCTL}, rd);
        check_reg(rd, m[7:0]);
      end
    end
    $display("control test done");
  endtask
  task automatic t_status;
    @(posedge i_core_clk);
    lv <= 8'hAA;
    repeat (5) @(posedge i_core_clk);
    rdr(4'h6, rd);
    check_reg(rd, 8'hFB);
    rdr(4'hE, rd);
    check_reg(rd, 8'h00);
    wr(4'h6, 8'h0F);
    rdr(4'h6, rd);
    check_reg(rd, 8'hF0);
    $display("status test done");
  endtask
  task automatic t_ring;
    int n;
    wr(4'h1, 8'h04);
    wr(4'h4, 8'h08);
    @(posedge i_core_clk);
    lv <= 8'hAB;
    for (n = 0; n < 10 && irq[0] !== 1'b1; n++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (n == 10) fail("no ring interrupt");
    if (n == 10) test_done;
    rdr(4'h6, rd);
    check_reg(rd, 8'hB4);
    wr(4'h6, 8'h04);
    @(posedge i_core_clk);
    #1 check_pin(irq, 2'h0);
    wr(4'h4, 8'h00);
    lv <= 8'hAA;
    repeat (4) @(posedge i_core_clk);
    lv <= 8'hAB;
    repeat (8) @(posedge i_core_clk);
    #1 check_pin(irq, 2'h0);
    rdr(4'h6, rd);
    check_reg(rd, 8'hB4);
    wr(4'h6, 8'h04);
    $display("ring test done");
  endtask
  task automatic t_tx;
    int n;
    logic [9:0] fr;
    fr = {1'b1, 8'hA5, 1'b0};
    wr(4'h2, 8'h03);
    wr(4'h0, 8'hA5);
    for (n = 0; n < 40 && txd[0] !== 1'b0; n++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (n == 40) fail("no start bit");
    if (n == 40) test_done;
    @(posedge i_core_clk);
    for (int i = 0; i < 10; i++) begin
      #1 check_pin(txd, {1'b1, fr[i]});
      repeat (4) @(posedge i_core_clk);
    end
    #1 check_pin(txd, 2'h3);
    $display("transmit test done");
  endtask
  task automatic t_loop;
    logic s, t;
    s = 1'b1;
    t = 1'b1;
    wr(4'h4, 8'h10);
    rx_drive <= 2'h1;
    repeat (2) @(posedge i_core_clk);
    rdr(4'h5, rd);
    check_reg(rd, 8'h02);
    wr(4'h0, 8'h00);
    for (int i = 0; i < 24; i++) begin
      rdr(4'h5, rd);
      s = s & rd[1];
      t = t & txd[0];
    end
    check_reg({7'h00, s}, 8'h00);
    check_reg({7'h00, t}, 8'h01);
    wr(4'h4, 8'h00);
    repeat (2) @(posedge i_core_clk);
    rdr(4'h5, rd);
    check_reg(rd, 8'h00);
    rx_val <= 2'h1;
    repeat (2) @(posedge i_core_clk);
    rdr(4'h5, rd);
    check_reg(rd, 8'h02);
    rx_drive <= 2'h0;
    rx_val <= 2'h0;
    $display("loopback test done");
  endtask
  task automatic t_rerst;
    wr(4'hC, 8'h03);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    #1 check_pin(dtr_n, 2'h3);
    check_pin(rts_n, 2'h3);
    rdr(4'hC, rd);
    check_reg(rd, 8'h00);
    $display("second reset test done");
  endtask
  // main sequence
  initial begin
    {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
    {lv, rx_drive, rx_val, num_errors, num_checks} = {8'hFF, 4'h0, 64'h0};
    repeat (6) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    t_reset;
    t_ctrl;
    t_status;
    t_ring;
    t_tx;
    t_loop;
    t_rerst;
    test_done;
  end
endmodule
